// >>> core/smh_consts.svh
// Constants for the modem handshake block of serial port one.
// Assumes inclusion by the package, the core module and the test bench.
//
// Notes on behaviour
// - Status bit 7 shows the inverted carrier detect input.
// - Status bit 3 sets when carrier detect rises since last status read.
// - Status bit 5 shows the inverted data set ready input.
// - Status bit 1 sets when data set ready rises since last status read.
// - Status bit 4 shows the inverted clear to send input.
// - Status bit 0 sets when clear to send rises since last status read.
// - With interrupt enable bit 3 and mask bit 0 set, clear to send changes interrupt.
// - With that enable and mask bits 3 and 1 set, carrier detect and data set ready changes interrupt.
// - Clear to send never gates or alters transmission.
// - Control bit 1 set drives request to send low.
// - Hardware reset drives request to send high, inactive.
// - Loop mode holds request to send inactive whatever the control bit.
`ifndef SMH_CONSTS_SVH
`define SMH_CONSTS_SVH

// Register byte addresses
`define SMH_ADDR_STATUS 8'h00
`define SMH_ADDR_CONTROL 8'h04
`define SMH_ADDR_INT_EN 8'h08
`define SMH_ADDR_EVENT 8'h0C
`define SMH_ADDR_MASK 8'h10

// Modem status fields
`define SMH_MS_CTS_CHG 0
`define SMH_MS_DSR_CHG 1
`define SMH_MS_DCD_CHG 3
`define SMH_MS_CTS 4
`define SMH_MS_DSR 5
`define SMH_MS_DCD 7

// Modem control fields
`define SMH_MC_RTS 1
`define SMH_MC_LOOP 4

// Interrupt enable field
`define SMH_IE_MODEM 3

// Input vector positions and event layout
`define SMH_IN_CTS 0
`define SMH_IN_DSR 1
`define SMH_IN_DCD 2

// Reset values
`define SMH_RST_BYTE 8'h00
`define SMH_RST_IN 3'h7

`endif

// >>> core/smh_pkg.sv
// Types for the modem handshake block.
// Assumes the constants header is on the include path.
`include "smh_consts.svh"
`default_nettype none

package smh_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} smh_apb_req_t;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic [2:0] chg_flag;
		logic [7:0] control;
		logic [7:0] int_en;
		logic [2:0] event_sts;
		logic [2:0] event_mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rts_n;
		logic irq;
	} smh_state_t;

endpackage : smh_pkg

`default_nettype wire

// >>> core/smh_ctrl.sv
// Modem handshake control for serial port one, reached over APB.
// Assumes modem inputs are asynchronous pins and the bus is on clk_sys.
//
// Added by the designer: the placing of the registers and the APB register port.
`include "smh_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module smh_ctrl
	import smh_pkg::*;
(
	input wire logic clk_sys, // 100 MHz clock
	input wire logic rst, // Async reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic carrier_detect_n, // Modem carrier detect
	input wire logic set_ready_n, // Modem data set ready
	input wire logic clear_to_send_n, // Modem clear to send
	output logic request_to_send_n, // Request to send to modem
	output logic irq // Level interrupt
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] mask3(input logic [2:0] v);
		logic [7:0] r;
		r = 8'h00;
		r[`SMH_MS_CTS_CHG] = v[`SMH_IN_CTS];
		r[`SMH_MS_DSR_CHG] = v[`SMH_IN_DSR];
		r[`SMH_MS_DCD_CHG] = v[`SMH_IN_DCD];
		return r;
	endfunction : mask3

	function automatic logic [2:0] unpack3(input logic [31:0] w);
		logic [2:0] r;
		r[`SMH_IN_CTS] = w[`SMH_MS_CTS_CHG];
		r[`SMH_IN_DSR] = w[`SMH_MS_DSR_CHG];
		r[`SMH_IN_DCD] = w[`SMH_MS_DCD_CHG];
		return r;
	endfunction : unpack3

	////////////////////////////////////////////////////////////////////////
	// State

	smh_state_t s;
	smh_state_t next_s;
	smh_apb_req_t req;
	logic [2:0] pin_in;
	logic [2:0] rise;
	logic [2:0] change;
	logic access;
	logic done;
	logic rd_status;
	logic [7:0] status_byte;
	logic hit;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite,
		paddr: paddr, pwdata: pwdata};
	assign pin_in = {carrier_detect_n, set_ready_n, clear_to_send_n};

	assign rise = s.sync2 & ~s.prev;
	assign change = s.sync2 ^ s.prev;
	assign access = req.psel && req.penable;
	assign done = access && s.pready;
	assign rd_status = done && !req.pwrite && req.paddr == `SMH_ADDR_STATUS;

	// Clear to send feeds the status and event bits only, nothing on the transmit side
	always_comb begin
		status_byte = mask3(s.chg_flag);
		status_byte[`SMH_MS_DCD] = ~s.sync2[`SMH_IN_DCD];
		status_byte[`SMH_MS_DSR] = ~s.sync2[`SMH_IN_DSR];
		status_byte[`SMH_MS_CTS] = ~s.sync2[`SMH_IN_CTS];
	end

	always_comb begin
		unique case (req.paddr)
			`SMH_ADDR_STATUS, `SMH_ADDR_CONTROL, `SMH_ADDR_INT_EN,
			`SMH_ADDR_EVENT, `SMH_ADDR_MASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;

		// Two stages before anything looks at the pins
		next_s.sync1 = pin_in;
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;

		// A rise in the same cycle as the read survives the clear
		next_s.chg_flag = (s.chg_flag & ~{3{rd_status}}) | rise;

		// Any edge is an interrupt event; set wins over write-one-clear
		next_s.event_sts = s.event_sts | change;

		// Bus answers one cycle into the access phase
		next_s.pready = access && !s.pready;
		next_s.pslverr = access && !s.pready && !hit;
		next_s.prdata = 32'h0000_0000;

		if (access && !s.pready && !req.pwrite) begin
			unique case (req.paddr)
				`SMH_ADDR_STATUS: next_s.prdata = {24'h00_0000, status_byte};
				`SMH_ADDR_CONTROL: next_s.prdata = {24'h00_0000, s.control};
				`SMH_ADDR_INT_EN: next_s.prdata = {24'h00_0000, s.int_en};
				`SMH_ADDR_EVENT: next_s.prdata = {24'h00_0000, mask3(s.event_sts)};
				`SMH_ADDR_MASK: next_s.prdata = {24'h00_0000, mask3(s.event_mask)};
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end

		if (done && req.pwrite) begin
			unique case (req.paddr)
				`SMH_ADDR_CONTROL: next_s.control = req.pwdata[7:0];
				`SMH_ADDR_INT_EN: next_s.int_en = req.pwdata[7:0];
				`SMH_ADDR_EVENT: begin
					next_s.event_sts = (s.event_sts & ~unpack3(req.pwdata)) | change;
				end
				`SMH_ADDR_MASK: next_s.event_mask = unpack3(req.pwdata);
				default: begin
				end
			endcase
		end

		// Loop mode forces the line inactive over the control bit
		next_s.rts_n = !(next_s.control[`SMH_MC_RTS] && !next_s.control[`SMH_MC_LOOP]);

		// One enable gates every modem event onto the line
		next_s.irq = next_s.int_en[`SMH_IE_MODEM]
			&& |(next_s.event_sts & next_s.event_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s.sync1 <= `SMH_RST_IN;
			s.sync2 <= `SMH_RST_IN;
			s.prev <= `SMH_RST_IN;
			s.chg_flag <= 3'h0;
			s.control <= `SMH_RST_BYTE;
			s.int_en <= `SMH_RST_BYTE;
			s.event_sts <= 3'h0;
			s.event_mask <= 3'h0;
			s.prdata <= 32'h0000_0000;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
			s.rts_n <= 1'b1;
			s.irq <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign request_to_send_n = s.rts_n;
	assign irq = s.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_dcd_level;
		pready && $past(rd_status ? 1'b0 : (access && !pwrite && paddr == `SMH_ADDR_STATUS))
			|-> prdata[`SMH_MS_DCD] == ~$past(s.sync2[`SMH_IN_DCD]);
	endproperty
	a_dcd_level: assert property (p_dcd_level) else $error("Carrier level bit wrong");

	property p_dcd_rise;
		rise[`SMH_IN_DCD] |=> s.chg_flag[`SMH_IN_DCD];
	endproperty
	a_dcd_rise: assert property (p_dcd_rise) else $error("Carrier change lost");

	property p_dsr_level;
		pready && $past(access && !pwrite && paddr == `SMH_ADDR_STATUS)
			|-> prdata[`SMH_MS_DSR] == ~$past(s.sync2[`SMH_IN_DSR]);
	endproperty
	a_dsr_level: assert property (p_dsr_level) else $error("Set ready level bit wrong");

	property p_dsr_rise;
		rise[`SMH_IN_DSR] |=> s.chg_flag[`SMH_IN_DSR];
	endproperty
	a_dsr_rise: assert property (p_dsr_rise) else $error("Set ready change lost");

	property p_cts_level;
		pready && $past(access && !pwrite && paddr == `SMH_ADDR_STATUS)
			|-> prdata[`SMH_MS_CTS] == ~$past(s.sync2[`SMH_IN_CTS]);
	endproperty
	a_cts_level: assert property (p_cts_level) else $error("Clear to send level bit wrong");

	property p_cts_rise;
		rise[`SMH_IN_CTS] |=> s.chg_flag[`SMH_IN_CTS];
	endproperty
	a_cts_rise: assert property (p_cts_rise) else $error("Clear to send change lost");

	property p_cts_irq;
		change[`SMH_IN_CTS] && s.int_en[`SMH_IE_MODEM] && s.event_mask[`SMH_IN_CTS]
			&& !(done && pwrite && (paddr == `SMH_ADDR_INT_EN || paddr == `SMH_ADDR_MASK))
			|=> irq;
	endproperty
	a_cts_irq: assert property (p_cts_irq) else $error("Clear to send change raised no interrupt");

	property p_dcd_dsr_irq;
		(change[`SMH_IN_DCD] && s.event_mask[`SMH_IN_DCD]
			|| change[`SMH_IN_DSR] && s.event_mask[`SMH_IN_DSR])
			&& s.int_en[`SMH_IE_MODEM]
			&& !(done && pwrite && (paddr == `SMH_ADDR_INT_EN || paddr == `SMH_ADDR_MASK))
			|=> irq;
	endproperty
	a_dcd_dsr_irq: assert property (p_dcd_dsr_irq) else $error("Modem change raised no interrupt");

	property p_irq_gate;
		!s.int_en[`SMH_IE_MODEM] && !(done && pwrite) |=> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without enable");

	property p_rts_drive;
		s.control[`SMH_MC_RTS] && !s.control[`SMH_MC_LOOP] && !(done && pwrite)
			|=> !request_to_send_n;
	endproperty
	a_rts_drive: assert property (p_rts_drive) else $error("Request to send not asserted");

	property p_rts_idle;
		!s.control[`SMH_MC_RTS] && !(done && pwrite) |=> request_to_send_n;
	endproperty
	a_rts_idle: assert property (p_rts_idle) else $error("Request to send asserted unbidden");

	property p_rts_loop;
		s.control[`SMH_MC_LOOP] && !(done && pwrite) |=> request_to_send_n;
	endproperty
	a_rts_loop: assert property (p_rts_loop) else $error("Request to send driven in loop mode");

	property p_read_clears;
		rd_status && !(|rise) |=> s.chg_flag == 3'h0;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("Status read left change bits");

	property p_single_set;
		!(|s.chg_flag) && !(|rise) |=> !(|s.chg_flag);
	endproperty
	a_single_set: assert property (p_single_set) else $error("Change bit set without an edge");

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held two cycles");

	// Zero outside the answer cycle, so a late sampler never takes stale data
	property p_rdata_idle;
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside ready");

	property p_upper_zero;
		pready |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("Upper read bits set");

	property p_ready_answer;
		access && !pready |=> pready;
	endproperty
	a_ready_answer: assert property (p_ready_answer) else $error("No ready after access");

	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("Error without ready");

	property p_err_unmapped;
		access && !pready && !hit |=> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("Unmapped access not refused");

	property p_err_mapped;
		access && !pready && hit |=> !pslverr;
	endproperty
	a_err_mapped: assert property (p_err_mapped) else $error("Mapped access refused");

	property p_dcd_chg_read;
		pready && $past(access && !pwrite && paddr == `SMH_ADDR_STATUS)
			|-> prdata[`SMH_MS_DCD_CHG] == $past(s.chg_flag[`SMH_IN_DCD]);
	endproperty
	a_dcd_chg_read: assert property (p_dcd_chg_read) else $error("Carrier change bit misread");

	property p_dsr_chg_read;
		pready && $past(access && !pwrite && paddr == `SMH_ADDR_STATUS)
			|-> prdata[`SMH_MS_DSR_CHG] == $past(s.chg_flag[`SMH_IN_DSR]);
	endproperty
	a_dsr_chg_read: assert property (p_dsr_chg_read) else $error("Set ready change bit misread");

	property p_cts_chg_read;
		pready && $past(access && !pwrite && paddr == `SMH_ADDR_STATUS)
			|-> prdata[`SMH_MS_CTS_CHG] == $past(s.chg_flag[`SMH_IN_CTS]);
	endproperty
	a_cts_chg_read: assert property (p_cts_chg_read) else $error("Send change bit misread");

	property p_event_set;
		|change |=> (s.event_sts & $past(change)) == $past(change);
	endproperty
	a_event_set: assert property (p_event_set) else $error("Modem change not recorded");

	property p_event_clear;
		done && pwrite && paddr == `SMH_ADDR_EVENT && pwdata[`SMH_MS_CTS_CHG]
			&& !change[`SMH_IN_CTS] |=> !s.event_sts[`SMH_IN_CTS];
	endproperty
	a_event_clear: assert property (p_event_clear) else $error("Event bit not cleared");

	property p_control_write;
		done && pwrite && paddr == `SMH_ADDR_CONTROL |=> s.control == $past(pwdata[7:0]);
	endproperty
	a_control_write: assert property (p_control_write) else $error("Control write lost");

	property p_int_en_write;
		done && pwrite && paddr == `SMH_ADDR_INT_EN |=> s.int_en == $past(pwdata[7:0]);
	endproperty
	a_int_en_write: assert property (p_int_en_write) else $error("Enable write lost");

	property p_mask_write;
		done && pwrite && paddr == `SMH_ADDR_MASK
			|=> s.event_mask[`SMH_IN_DCD] == $past(pwdata[`SMH_MS_DCD_CHG]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("Mask write lost");

	property p_rts_hold;
		!(done && pwrite) |=> $stable(request_to_send_n);
	endproperty
	a_rts_hold: assert property (p_rts_hold) else $error("Request to send moved unbidden");

	property p_irq_source;
		irq |-> s.int_en[`SMH_IE_MODEM] && |(s.event_sts & s.event_mask);
	endproperty
	a_irq_source: assert property (p_irq_source) else $error("Interrupt without event");

	property p_chg_hold;
		!rd_status |=> (s.chg_flag & $past(s.chg_flag)) == $past(s.chg_flag);
	endproperty
	a_chg_hold: assert property (p_chg_hold) else $error("Change bit lost without read");

endmodule : smh_ctrl

`default_nettype wire

// >>> test/smh_modem.sv
// Modem model standing on the far side of the handshake pins.
// Assumes the bench calls drive() and that the model shares clk_sys.
`timescale 1ns/100ps
`default_nettype none

module smh_modem (
	input wire logic clk_sys, // Shared clock
	input wire logic request_to_send_n, // Request from the block, only observed
	output var logic carrier_detect_n, // Carrier detect pin
	output var logic set_ready_n, // Data set ready pin
	output var logic clear_to_send_n // Clear to send pin
);
	// Pins idle high until the bench asks for a level; order is dcd, dsr, cts
	logic [2:0] lines = 3'h7;

	always_comb begin
		carrier_detect_n = lines[2];
		set_ready_n = lines[1];
		clear_to_send_n = lines[0];
	end

	// Level changes land right after an edge, never on it
	task automatic drive(input logic [2:0] v);
		@(posedge clk_sys);
		lines <= v;
	endtask : drive
endmodule : smh_modem
`default_nettype wire

// >>> test/smh_ctrl_test.sv
// Self-checking bench for the modem handshake block.
// Assumes the APB slave answers with a wait state and pins are modelled by smh_modem.
`include "smh_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module smh_ctrl_test;
	import smh_pkg::*;
	logic clk_sys = 0;
	logic rst = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic dcd_n, dsr_n, cts_n, rts_n, irq;
	int error_cnt = 0;
	int checks_done = 0;

	always #5 clk_sys = ~clk_sys;

	smh_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .carrier_detect_n(dcd_n), .set_ready_n(dsr_n),
		.clear_to_send_n(cts_n), .request_to_send_n(rts_n), .irq(irq));
	smh_modem i_modem (.clk_sys(clk_sys), .request_to_send_n(rts_n),
		.carrier_detect_n(dcd_n), .set_ready_n(dsr_n), .clear_to_send_n(cts_n));

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t data %h expected %h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			error_cnt++;
			$display("BAD %0t no ready", $time);
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic pins(input logic [2:0] v);
		i_modem.drive(v);
		repeat (6) @(posedge clk_sys);
	endtask : pins

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 0;
		chk1(rts_n, 1'b1);
		apb(0, `SMH_ADDR_STATUS, 0);
		chk32(rd, 32'h0000_0000);
		$display("reset test done");
		pins(3'h0);
		apb(0, `SMH_ADDR_STATUS, 0);
		chk32(rd, 32'h0000_00B0);
		pins(3'h7);
		apb(0, `SMH_ADDR_STATUS, 0);
		chk32(rd, 32'h0000_000B);
		apb(0, `SMH_ADDR_STATUS, 0);
		chk32(rd, 32'h0000_0000);
		chk1(err, 1'b0);
		$display("status test done");
		apb(1, `SMH_ADDR_CONTROL, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		chk1(rts_n, 1'b0);
		apb(1, `SMH_ADDR_CONTROL, 32'h0000_0012);
		repeat (2) @(posedge clk_sys);
		chk1(rts_n, 1'b1);
		apb(0, `SMH_ADDR_CONTROL, 0);
		chk32(rd, 32'h0000_0012);
		$display("request test done");
		apb(1, `SMH_ADDR_EVENT, 32'h0000_000B);
		apb(1, `SMH_ADDR_INT_EN, 32'h0000_0008);
		apb(1, `SMH_ADDR_MASK, 32'h0000_0001);
		pins(3'h6);
		chk1(irq, 1'b1);
		apb(1, `SMH_ADDR_EVENT, 32'h0000_0001);
		@(posedge clk_sys);
		chk1(irq, 1'b0);
		apb(1, `SMH_ADDR_MASK, 32'h0000_0008);
		pins(3'h7);
		chk1(irq, 1'b0);
		apb(0, `SMH_ADDR_EVENT, 0);
		chk32(rd, 32'h0000_0001);
		apb(1, `SMH_ADDR_EVENT, 32'h0000_0001);
		pins(3'h3);
		chk1(irq, 1'b1);
		apb(1, `SMH_ADDR_EVENT, 32'h0000_0008);
		apb(1, `SMH_ADDR_MASK, 32'h0000_0002);
		pins(3'h1);
		chk1(irq, 1'b1);
		apb(1, `SMH_ADDR_INT_EN, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		chk1(irq, 1'b0);
		$display("interrupt test done");
		apb(0, 8'h20, 0);
		chk32(rd, 32'h0000_0000);
		chk1(err, 1'b1);
		$display("unmapped test done");
		print_verdict();
	end
endmodule : smh_ctrl_test
`default_nettype wire
